// >>> src/uad_consts.svh
`ifndef UAD_CONSTS_SVH
`define UAD_CONSTS_SVH

// ==========================================================================
// register byte offsets on the apb side
`define UAD_OFF_TXCTRL  8'h00
`define UAD_OFF_RXCTRL  8'h04
`define UAD_OFF_BAUD    8'h08
`define UAD_OFF_TXDATA  8'h0c
`define UAD_OFF_RXDATA  8'h10
`define UAD_OFF_ISTAT   8'h14
`define UAD_OFF_IMASK   8'h18
`define UAD_OFF_FLAGS   8'h1c

// ==========================================================================
// transmit_status_control bit positions
`define UAD_TX_CLKSRC   7
`define UAD_TX_NINE_EN  6
`define UAD_TX_EN       5
`define UAD_TX_SYNC     4
`define UAD_TX_HSBAUD   2
`define UAD_TX_SHEMPTY  1
`define UAD_TX_NINTH    0

// rx_status_control bit positions
`define UAD_RC_PORTEN   7
`define UAD_RC_NINE_EN  6
`define UAD_RC_SREN     5
`define UAD_RC_CONTEN   4
`define UAD_RC_ADDRDET  3
`define UAD_RC_FERR     2
`define UAD_RC_OVERRUN  1
`define UAD_RC_NINTH    0

// interrupt status / mask bit positions
`define UAD_IRQ_RX      0
`define UAD_IRQ_OVR     1
`define UAD_IRQ_FERR    2
`define UAD_IRQ_TXE     3
`define UAD_IRQ_W       4

// ==========================================================================
// reset values and timing counts
`define UAD_TXCTRL_RST  8'h02
`define UAD_OVS_LAST    4'hf
`define UAD_OVS_MID     4'h7
`define UAD_LS_PAD      2'b11
`define UAD_FIFO_FULL   2'h2
`define UAD_TX_BITS8    4'h9
`define UAD_TX_BITS9    4'ha
`define UAD_RX_BITS8    4'h7
`define UAD_RX_BITS9    4'h8

`endif

// >>> src/uad_pkg.sv
package uad_pkg;

  // receive framing states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } uad_rx_st_e;

  // one entry of the receive buffer
  typedef struct packed {
    logic       ferr;
    logic       ninth;
    logic [7:0] data;
  } uad_rx_entry_s;

endpackage

// >>> src/uad_baud_gen.sv
`timescale 1ns/10ps
`include "uad_consts.svh"

module uad_baud_gen import uad_pkg::*; (
  input  wire logic       clk,         // system clock
  input  wire logic       rst_n,       // async reset, active low
  input  wire logic [7:0] divisor,     // baud_divisor value
  input  wire logic       high_speed,  // 1: divide by n+1, 0: by 4(n+1)
  input  wire logic       run,         // generator enabled
  output logic            tick         // one-cycle oversample tick
);

  logic [9:0] cnt_q;
  logic [9:0] limit;

  // low speed stretches the period by four
  assign limit = high_speed ? {2'b00, divisor} : {divisor, `UAD_LS_PAD};

  // ==========================================================================
  // divider; restarts whenever the port is off so phase is clean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 10'h000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 10'h000;
      tick  <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 10'h000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 10'h001;
      tick  <= 1'b0;
    end
  end

endmodule // uad_baud_gen

// >>> src/uad_serial_top.sv
// Overview of operation
// RQ1: address mode passes only ninth-bit-set characters
// RQ2: interrupt when rx flag sets and enabled
// RQ3: address mode characters read ninth bit one
// RQ4: address detect off passes every character
// RQ5: clearing continuous receive clears overrun flag
// RQ6: host configures baud, port, nine-bit, detect, receive
// RQ7: third word before read sets overrun
// RQ8: clock select: ignored async, master/slave sync
// RQ9: nine-bit transmit sends stored ninth bit
// RQ10: shift-empty status read-only, resets to one
// RQ11: high-speed select only acts in async mode
// RQ12: start low, lsb-first data, stop high
// RQ13: tx empty flag: enabled and buffer empty
`timescale 1ns/10ps
`include "uad_consts.svh"

module uad_serial_top import uad_pkg::*; (
  input  wire logic        pclk,       // system clock, 10 MHz
  input  wire logic        presetn,    // async reset, active low
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data
  output logic             pready,     // apb ready, always one
  output logic             pslverr,    // apb error on unmapped address
  input  wire logic        rx_pin,     // serial receive line
  output logic             tx_pin_o,   // serial transmit level
  output logic             tx_pin_oe,  // transmit pin driven
  output logic             ck_pin_o,   // sync master clock level
  output logic             ck_pin_oe,  // clock pin driven (master)
  output logic             irq         // level interrupt
);

  // ==========================================================================
  // control registers
  logic       clk_src_sel_q, tx_nine_en_q, tx_en_q, sync_q, hs_baud_q, tx_ninth_q;
  logic       port_en_q, rx_nine_en_q, sren_q, cont_rx_en_q, addr_det_en_q;
  logic [7:0] baud_q;
  logic [`UAD_IRQ_W-1:0] istat_q, imask_q, ev;

  logic access, wr, rd, hit, setup;
  assign access = psel & penable;
  assign setup  = psel & ~penable;
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;

  // zero-wait slave; unmapped offsets answer with an error
  assign pready = 1'b1;
  always_comb begin
    if      (paddr == `UAD_OFF_TXCTRL) hit = 1'b1;
    else if (paddr == `UAD_OFF_RXCTRL) hit = 1'b1;
    else if (paddr == `UAD_OFF_BAUD)   hit = 1'b1;
    else if (paddr == `UAD_OFF_TXDATA) hit = 1'b1;
    else if (paddr == `UAD_OFF_RXDATA) hit = 1'b1;
    else if (paddr == `UAD_OFF_ISTAT)  hit = 1'b1;
    else if (paddr == `UAD_OFF_IMASK)  hit = 1'b1;
    else if (paddr == `UAD_OFF_FLAGS)  hit = 1'b1;
    else                               hit = 1'b0;
  end
  assign pslverr = access & ~hit;

  // config writes; shift-empty bit is not writable [RQ10]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clk_src_sel_q, tx_nine_en_q, tx_en_q, sync_q} <= 4'h0;
      {hs_baud_q, tx_ninth_q}                        <= 2'b00;
      {port_en_q, rx_nine_en_q, sren_q, cont_rx_en_q, addr_det_en_q} <= 5'h00;
      baud_q  <= 8'h00;
      imask_q <= '0;
    end else if (wr) begin
      if (paddr == `UAD_OFF_TXCTRL) begin
        clk_src_sel_q <= pwdata[`UAD_TX_CLKSRC];
        tx_nine_en_q  <= pwdata[`UAD_TX_NINE_EN];
        tx_en_q       <= pwdata[`UAD_TX_EN];
        sync_q        <= pwdata[`UAD_TX_SYNC];
        hs_baud_q     <= pwdata[`UAD_TX_HSBAUD];
        tx_ninth_q    <= pwdata[`UAD_TX_NINTH];
      end else if (paddr == `UAD_OFF_RXCTRL) begin
        port_en_q     <= pwdata[`UAD_RC_PORTEN];
        rx_nine_en_q  <= pwdata[`UAD_RC_NINE_EN];
        sren_q        <= pwdata[`UAD_RC_SREN];
        cont_rx_en_q  <= pwdata[`UAD_RC_CONTEN];
        addr_det_en_q <= pwdata[`UAD_RC_ADDRDET];
      end else if (paddr == `UAD_OFF_BAUD) begin
        baud_q <= pwdata[7:0];
      end else if (paddr == `UAD_OFF_IMASK) begin
        imask_q <= pwdata[`UAD_IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // baud generator; high speed select ignored in sync mode
  logic tick;
  uad_baud_gen u_baud (
    .clk        (pclk),
    .rst_n      (presetn),
    .divisor    (baud_q),
    .high_speed (hs_baud_q | sync_q),  // [RQ11]
    .run        (port_en_q),
    .tick       (tick)
  );

  // ==========================================================================
  // receive line synchroniser, idles at mark
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // ==========================================================================
  // receive framing at sixteen ticks per bit
  uad_rx_st_e rx_st_q;
  logic [3:0] rx_ovs_q, rx_bit_q;
  logic [8:0] rx_sh_q;
  logic       overrun_q, rx_on, rx_done, rx_ferr, accept, push, pop, ovr_set;
  uad_rx_entry_s rx_new;

  // reception halts while an overrun is pending
  assign rx_on = port_en_q & cont_rx_en_q & ~sync_q & ~overrun_q;

  // lsb first; eight-bit frames end up in the upper bits [RQ12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q  <= RX_IDLE;
      rx_ovs_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 9'h000;
    end else if (!rx_on) begin
      rx_st_q <= RX_IDLE;
    end else if (tick) begin
      rx_ovs_q <= rx_ovs_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_ovs_q <= 4'h0;
          if (!rx_s2_q) rx_st_q <= RX_START;
        end
        RX_START: begin
          if (rx_ovs_q == `UAD_OVS_MID) begin
            rx_ovs_q <= 4'h0;
            rx_bit_q <= 4'h0;
            // glitch shorter than half a bit is not a start
            rx_st_q  <= rx_s2_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_ovs_q == `UAD_OVS_LAST) begin
            rx_sh_q  <= {rx_s2_q, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == (rx_nine_en_q ? `UAD_RX_BITS9 : `UAD_RX_BITS8)) rx_st_q <= RX_STOP;
          end
        end
        default: begin
          if (rx_ovs_q == `UAD_OVS_LAST) rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  assign rx_done      = rx_on & tick & (rx_st_q == RX_STOP) & (rx_ovs_q == `UAD_OVS_LAST);
  assign rx_ferr      = ~rx_s2_q;
  assign rx_new.ferr  = rx_ferr;
  assign rx_new.ninth = rx_nine_en_q & rx_sh_q[8];
  assign rx_new.data  = rx_nine_en_q ? rx_sh_q[7:0] : rx_sh_q[8:1];

  // address mode drops data characters; detect off passes all [RQ1] [RQ4]
  assign accept  = rx_done & ~(addr_det_en_q & rx_nine_en_q & ~rx_new.ninth);

  // ==========================================================================
  // two-deep receive buffer; a third word with no room is an overrun
  uad_rx_entry_s rx_mem_q [2];
  logic          wptr_q, rptr_q;
  logic [1:0]    cnt_q;
  uad_rx_entry_s head;

  assign head    = (cnt_q != 2'h0) ? rx_mem_q[rptr_q] : '0;
  assign pop     = rd & (paddr == `UAD_OFF_RXDATA) & (cnt_q != 2'h0);
  assign push    = accept & ((cnt_q != `UAD_FIFO_FULL) | pop);
  assign ovr_set = accept & (cnt_q == `UAD_FIFO_FULL) & ~pop;  // [RQ7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_mem_q[0] <= '0;
      rx_mem_q[1] <= '0;
      wptr_q      <= 1'b0;
      rptr_q      <= 1'b0;
      cnt_q       <= 2'h0;
    end else begin
      if (push) begin
        rx_mem_q[wptr_q] <= rx_new;
        wptr_q           <= ~wptr_q;
      end
      if (pop) rptr_q <= ~rptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // overrun flag; only cleared by dropping continuous receive [RQ5] [RQ7]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)           overrun_q <= 1'b0;
    else if (!cont_rx_en_q) overrun_q <= 1'b0;
    else if (ovr_set)       overrun_q <= 1'b1;
  end

  // ==========================================================================
  // transmit buffer and shift register
  logic [7:0]  txbuf_q;
  logic        txbuf_v_q, tx_busy_q, txd_q, tx_load, wr_tx, tx_empty, tx_empty_q;
  logic [9:0]  tx_shift_q;
  logic [3:0]  tx_ovs_q, tx_left_q;

  assign wr_tx    = wr & (paddr == `UAD_OFF_TXDATA);
  assign tx_load  = txbuf_v_q & ~tx_busy_q & tx_en_q & port_en_q & ~sync_q;
  assign tx_empty = tx_en_q & ~txbuf_v_q;  // [RQ13]

  // a write in the load cycle is kept, the old byte goes out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txbuf_q   <= 8'h00;
      txbuf_v_q <= 1'b0;
    end else if (wr_tx) begin
      txbuf_q   <= pwdata[7:0];
      txbuf_v_q <= 1'b1;
    end else if (tx_load) begin
      txbuf_v_q <= 1'b0;
    end
  end

  // start bit leaves at load, then data lsb first, ninth, stop [RQ9] [RQ12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_q <= 10'h3ff;
      tx_busy_q  <= 1'b0;
      txd_q      <= 1'b1;
      tx_ovs_q   <= 4'h0;
      tx_left_q  <= 4'h0;
    end else if (!tx_en_q || !port_en_q) begin
      tx_busy_q <= 1'b0;
      txd_q     <= 1'b1;
    end else if (tx_load) begin
      tx_shift_q <= {1'b1, tx_nine_en_q ? tx_ninth_q : 1'b1, txbuf_q};
      tx_busy_q  <= 1'b1;
      txd_q      <= 1'b0;
      tx_ovs_q   <= 4'h0;
      tx_left_q  <= tx_nine_en_q ? `UAD_TX_BITS9 : `UAD_TX_BITS8;
    end else if (tx_busy_q && tick) begin
      tx_ovs_q <= tx_ovs_q + 4'h1;
      if (tx_ovs_q == `UAD_OVS_LAST) begin
        if (tx_left_q == 4'h0) begin
          tx_busy_q <= 1'b0;
        end else begin
          txd_q      <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          tx_left_q <= tx_left_q - 4'h1;
        end
      end
    end
  end

  assign tx_pin_o  = txd_q;
  assign tx_pin_oe = port_en_q;

  // clock pin driven only as sync master; async mode ignores select [RQ8]
  logic ck_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                                    ck_q <= 1'b0;
    else if (!(sync_q && clk_src_sel_q && port_en_q)) ck_q <= 1'b0;
    else if (tick)                                   ck_q <= ~ck_q;
  end
  assign ck_pin_o  = ck_q;
  assign ck_pin_oe = port_en_q & sync_q & clk_src_sel_q;

  // ==========================================================================
  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_empty_q <= 1'b0;
    else          tx_empty_q <= tx_empty;
  end

  always_comb begin
    ev                = '0;
    ev[`UAD_IRQ_RX]   = push;  // [RQ2]
    ev[`UAD_IRQ_OVR]  = ovr_set;
    ev[`UAD_IRQ_FERR] = push & rx_ferr;
    ev[`UAD_IRQ_TXE]  = tx_empty & ~tx_empty_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) istat_q <= '0;
    else if (wr && paddr == `UAD_OFF_ISTAT) istat_q <= (istat_q & ~pwdata[`UAD_IRQ_W-1:0]) | ev;
    else istat_q <= istat_q | ev;
  end

  assign irq = |(istat_q & imask_q);  // [RQ2]

  // ==========================================================================
  // read data captured in setup so it is stable through access
  logic [7:0] tx_ctrl_rd, rx_ctrl_rd;
  assign tx_ctrl_rd = {clk_src_sel_q, tx_nine_en_q, tx_en_q, sync_q, 1'b0, hs_baud_q, ~tx_busy_q,
                       tx_ninth_q};  // [RQ10]
  assign rx_ctrl_rd = {port_en_q, rx_nine_en_q, sren_q, cont_rx_en_q, addr_det_en_q, head.ferr,
                       overrun_q, head.ninth};  // [RQ3]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (setup && !pwrite) begin
      if      (paddr == `UAD_OFF_TXCTRL) prdata <= {24'h000000, tx_ctrl_rd};
      else if (paddr == `UAD_OFF_RXCTRL) prdata <= {24'h000000, rx_ctrl_rd};
      else if (paddr == `UAD_OFF_BAUD)   prdata <= {24'h000000, baud_q};
      else if (paddr == `UAD_OFF_RXDATA) prdata <= {24'h000000, head.data};
      else if (paddr == `UAD_OFF_ISTAT)  prdata <= {28'h0000000, istat_q};
      else if (paddr == `UAD_OFF_IMASK)  prdata <= {28'h0000000, imask_q};
      else if (paddr == `UAD_OFF_FLAGS)  prdata <= {30'h00000000, tx_empty, cnt_q != 2'h0};
      else                               prdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start_low;
    !txd_q [*8];
  endsequence

  a_addr_filter: assert property (  // [RQ1]
    (rx_done && addr_det_en_q && rx_nine_en_q && !rx_new.ninth && !pop) |=> $stable(cnt_q))
    else $error("data character entered buffer in address mode");

  a_irq_rx: assert property (  // [RQ2]
    (push && imask_q[`UAD_IRQ_RX]) |=> irq)
    else $error("rx interrupt not raised");

  a_addr_ninth: assert property (  // [RQ3]
    (push && cnt_q == 2'h0 && !pop && addr_det_en_q && rx_nine_en_q) |=> rx_ctrl_rd[`UAD_RC_NINTH])
    else $error("address character does not read ninth bit one");

  a_pass_all: assert property (  // [RQ4]
    (rx_done && !addr_det_en_q && cnt_q == 2'h0 && !pop) |=> (cnt_q == 2'h1))
    else $error("character lost with detect off");

  a_overrun_error_flag_clear: assert property (  // [RQ5]
    !cont_rx_en_q |=> !overrun_q)
    else $error("overrun flag survived receive disable");

  a_overrun_set: assert property (  // [RQ7]
    (accept && cnt_q == `UAD_FIFO_FULL && !pop) |=> (overrun_q && cnt_q == `UAD_FIFO_FULL))
    else $error("third word did not flag overrun");

  a_clk_master: assert property (  // [RQ8]
    (!sync_q || !clk_src_sel_q) |-> !ck_pin_oe)
    else $error("clock pin driven outside sync master");

  a_tx_ninth: assert property (  // [RQ9]
    (tx_load && tx_nine_en_q) |=> (tx_shift_q[8] == $past(tx_ninth_q)))
    else $error("ninth transmit bit not taken from register");

  a_tx_shift_empty_busy: assert property (  // [RQ10]
    $rose(tx_busy_q) |-> !tx_ctrl_rd[`UAD_TX_SHEMPTY] ##1 !tx_ctrl_rd[`UAD_TX_SHEMPTY])
    else $error("shift empty status wrong while sending");

  a_start_bit: assert property (  // [RQ12]
    tx_load |=> s_start_low)
    else $error("start bit shorter than expected");

  a_tx_buffer_empty_flag_busy: assert property (  // [RQ13]
    (wr_tx && tx_busy_q && tx_en_q) |=> !tx_empty)
    else $error("tx empty flag set with character queued");

endmodule // uad_serial_top

// >>> test/uad_line_peer.sv
`timescale 1ns/10ps

// ==========================================================================
// serial peer: sends frames into the device, watches its transmit line
module uad_line_peer #(
  parameter int BIT_CLKS = 16  // clocks per bit at div 0, high speed
) (
  input  wire logic clk,        // system clock
  input  wire logic nine_mode,  // expect nine data bits from the device
  input  wire logic line_i,     // device transmit level
  output logic      line_o      // device receive level
);
  logic [8:0] cap_q;   // data of the last frame seen
  logic       stop_q;  // stop level of that frame
  int         frames;  // frames seen so far
  int         i;

  // line pulled up, so idle is mark
  initial begin
    line_o = 1'b1;
    cap_q  = '0;
    stop_q = 1'b0;
    frames = 0;
  end

  // start at space, lsb first, one stop at mark
  task automatic send(input logic [8:0] v, input logic nine);
    int b;
    @(posedge clk);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (b = 0; b < (nine ? 9 : 8); b++) begin
      line_o <= v[b];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line_o <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask

  // sample mid-bit on the falling edge, away from the launch edge
  always begin
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(negedge clk);
    if (line_i === 1'b0) begin
      cap_q = '0;
      for (i = 0; i < (nine_mode ? 9 : 8); i++) begin
        repeat (BIT_CLKS) @(negedge clk);
        cap_q[i] = line_i;
      end
      repeat (BIT_CLKS) @(negedge clk);
      stop_q = line_i;
      frames++;
    end
  end
endmodule // uad_line_peer

// >>> test/uad_serial_top_tb.sv
`timescale 1ns/10ps
`include "uad_consts.svh"

module uad_serial_top_tb;
  typedef struct packed {
    logic       address_detect_enable;
    logic       ninth;
    logic [7:0] data;
    logic       msk;
    logic       buffered;
  } uad_row_s;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, nine;
  logic        rx_pin, tx_pin_o, tx_pin_oe, ck_pin_o, ck_pin_oe, irq, ck_v;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          error_cnt, checks_done, r;
  // address filter on and off, with and without the mask
  uad_row_s    rows [5] = '{'{1, 0, 8'h3a, 1, 0}, '{1, 1, 8'h5c, 1, 1}, '{1, 1, 8'hff, 0, 1},
                            '{0, 0, 8'h00, 1, 1}, '{0, 1, 8'h81, 1, 1}};

  uad_serial_top uad_serial_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
    .ck_pin_o(ck_pin_o), .ck_pin_oe(ck_pin_oe), .irq(irq));
  uad_line_peer uad_line_peer_inst (.clk(pclk), .nine_mode(nine), .line_i(tx_pin_o), .line_o(rx_pin));

  // ==========================================================================
  // clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ==========================================================================
  // helpers
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pins settle after the edge's updates, so look at the falling edge;
  // by reference, so the value seen is the one at that edge, not at the call
  task automatic chk_pin(input string what, input logic exp, ref logic got);
    @(negedge pclk);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  // one apb transfer; the wait on pready is bounded, never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      close_out();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd & m);
  endtask

  task automatic wait_frames(input int n);
    int k;
    for (k = 0; k < 4000 && uad_line_peer_inst.frames < n; k++)
      @(posedge pclk);
    if (uad_line_peer_inst.frames < n) begin
      error_cnt++;
      close_out();
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nine = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_pin("irq_rst", 1'b0, irq);
    rdchk("txctrl_rst", `UAD_OFF_TXCTRL, 32'hffffffff, {24'h0, `UAD_TXCTRL_RST});
    rdchk("rxctrl_rst", `UAD_OFF_RXCTRL, 32'hffffffff, 32'h0);
    // baud, then high speed, then port on, nine bits, filter and receive in one write
    wr(`UAD_OFF_BAUD, 32'h0);
    wr(`UAD_OFF_TXCTRL, 32'h04);
    wr(`UAD_OFF_RXCTRL, 32'hd8);
    for (r = 0; r < 5; r++) begin
      wr(`UAD_OFF_RXCTRL, rows[r].address_detect_enable ? 32'hd8 : 32'hd0);
      wr(`UAD_OFF_IMASK, {31'h0, rows[r].msk});
      uad_line_peer_inst.send({rows[r].ninth, rows[r].data}, 1'b1);
      repeat (4) @(posedge pclk);
      rdchk("rx_flag", `UAD_OFF_FLAGS, 32'h1, {31'h0, rows[r].buffered});
      chk_pin("rx_irq", rows[r].buffered & rows[r].msk, irq);
      if (rows[r].buffered) begin
        rdchk("rx_ninth", `UAD_OFF_RXCTRL, 32'h1, {31'h0, rows[r].ninth});
        rdchk("rx_data", `UAD_OFF_RXDATA, 32'hff, {24'h0, rows[r].data});
        wr(`UAD_OFF_ISTAT, 32'h1);
        chk_pin("irq_clr", 1'b0, irq);
      end
    end
    // three words with no read in between
    wr(`UAD_OFF_IMASK, 32'h2);
    uad_line_peer_inst.send(9'h111, 1'b1);
    uad_line_peer_inst.send(9'h122, 1'b1);
    uad_line_peer_inst.send(9'h133, 1'b1);
    repeat (4) @(posedge pclk);
    rdchk("ovr_set", `UAD_OFF_RXCTRL, 32'h2, 32'h2);
    chk_pin("ovr_irq", 1'b1, irq);
    rdchk("ovr_head", `UAD_OFF_RXDATA, 32'hff, 32'h11);
    wr(`UAD_OFF_RXCTRL, 32'hc0);
    rdchk("ovr_clr", `UAD_OFF_RXCTRL, 32'h2, 32'h0);
    rdchk("ovr_second", `UAD_OFF_RXDATA, 32'hff, 32'h22);
    rdchk("ovr_empty", `UAD_OFF_RXDATA, 32'hff, 32'h0);
    wr(`UAD_OFF_ISTAT, 32'hf);
    wr(`UAD_OFF_IMASK, 32'h0);
    // nine-bit transmit, second byte queued behind the first
    nine <= 1'b1;
    wr(`UAD_OFF_TXCTRL, 32'h65);
    chk_pin("tx_oe", 1'b1, tx_pin_oe);
    rdchk("tx_empty", `UAD_OFF_FLAGS, 32'h2, 32'h2);
    wr(`UAD_OFF_TXDATA, 32'ha5);
    wr(`UAD_OFF_TXDATA, 32'h3c);
    rdchk("tx_queued", `UAD_OFF_FLAGS, 32'h2, 32'h0);
    wr(`UAD_OFF_TXCTRL, 32'h67);
    rdchk("shempty_ro", `UAD_OFF_TXCTRL, 32'hff, 32'h65);
    wait_frames(1);
    chk("tx_frame1", 32'h1a5, {23'h0, uad_line_peer_inst.cap_q});
    chk("tx_stop1", 32'h1, {31'h0, uad_line_peer_inst.stop_q});
    wait_frames(2);
    chk("tx_frame2", 32'h13c, {23'h0, uad_line_peer_inst.cap_q});
    repeat (20) @(posedge pclk);
    rdchk("shempty_idle", `UAD_OFF_TXCTRL, 32'h2, 32'h2);
    rdchk("tx_drained", `UAD_OFF_FLAGS, 32'h2, 32'h2);
    // clock pin: master only in sync mode with source select set
    wr(`UAD_OFF_TXCTRL, 32'h90);
    chk_pin("ck_master", 1'b1, ck_pin_oe);
    // at divisor zero the master clock flips on every system clock
    ck_v = ck_pin_o;
    chk_pin("ck_toggle", ~ck_v, ck_pin_o);
    wr(`UAD_OFF_TXCTRL, 32'h10);
    chk_pin("ck_slave", 1'b0, ck_pin_oe);
    wr(`UAD_OFF_TXCTRL, 32'h80);
    chk_pin("ck_async", 1'b0, ck_pin_oe);
    // unmapped word answers with an error and reads zero
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    close_out();
  end
endmodule // uad_serial_top_tb
